// [rtl/gpio_pins.sv]
// Contract
// RL1 - Each pin has its own direction bit, input or output
// RL2 - Set, clear and toggle writes touch only pins written with one
// RL3 - Per-pin mask decides whether the pin may interrupt
// RL4 - Input pins interrupt from the pin, output pins from software data
// RL5 - Per-pin level or edge; edge is rising only or both edges
// RL6 - Pin interrupt channels detect edge or level with programmable polarity
// RL7 - Pin interrupt channels sample raw pins, independent of port settings
// RL8 - Eight pin interrupt channels, each with its own interrupt output
// RL9 - Each channel serves up to 32 pins
// RL10 - Channels take pins as programmable half ports of eight
// RL11 - Each channel has 32-bit mask, request, latch and assignment registers
// RL12 - Pin state and latches are readable even when masked
// RL13 - Channel control registers have write-one-set and write-one-clear aliases
// RL14 - Edge request latches until software writes one to clear it
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpio_pins #(
   parameter int NPORTS = 2
) (
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   input  wire logic [gpio_pkg::AW-1:0]            addr,
   input  wire logic [gpio_pkg::DW-1:0]            wdata,
   input  wire logic                               wr,
   input  wire logic                               rd,
   output logic      [gpio_pkg::DW-1:0]            rdata,
   input  wire logic [NPORTS*gpio_pkg::PORT_W-1:0] pin_in,
   output logic      [NPORTS*gpio_pkg::PORT_W-1:0] pin_out,
   output logic      [NPORTS*gpio_pkg::PORT_W-1:0] pin_oe,
   output logic                                    gpio_irq,
   output logic      [gpio_pkg::NCH-1:0]           pin_irq_channels
);
   import gpio_pkg::*;
   localparam int NP    = NPORTS * PORT_W;
   localparam int NHALF = NP / HALF_W;
   localparam int PADW  = DW - PORT_W;

   logic [NP-1:0]    data_q;
   logic [NP-1:0]    dir_q;
   logic [NP-1:0]    mask_q;
   logic [NP-1:0]    edge_q;
   logic [NP-1:0]    both_q;
   logic [NP-1:0]    stat_q;
   logic [NP-1:0]    prev_q;
   logic [DW-1:0]    rdata_q;
   logic             gpio_irq_q;
   logic [NP-1:0]    data_d;
   logic [NP-1:0]    dir_d;
   logic [NP-1:0]    mask_d;
   logic [NP-1:0]    edge_d;
   logic [NP-1:0]    both_d;
   logic [NP-1:0]    stat_d;
   logic [NP-1:0]    src;
   logic [NP-1:0]    ev;
   logic [DW-1:0]    port_rv [NPORTS];
   logic [DW-1:0]    ch_rv   [NCH];
   logic [DW-1:0]    rd_val;
   wop_t             op;

   wire logic [1:0]  grp     = addr[5:4];
   wire logic [3:0]  port_ix = addr[9:6];
   wire logic [2:0]  ch_ix   = addr[8:6];
   wire logic        in_port = (addr[11:10] == PORT_HI) && (int'(port_ix) < NPORTS);
   wire logic        in_ch   = (addr[11:9] == CH_HI);
   wire logic        plain   = addr[3:2] != OP_XTRA;

   assign op = wop_t'(addr[3:2]);

   // Output pins feed their own driven level back as the interrupt source
   assign src = (dir_q & data_q) | (~dir_q & pin_in); // RL4

   genvar p;
   generate
      for (p = 0; p < NPORTS; p++) begin : g_port
         wire logic hit  = in_port && (port_ix == 4'(p));
         wire logic whit = wr && hit;
         wire logic rclr = rd && hit && grp == G_MISC && addr[3:2] == M_STAT;
         wire logic [PORT_W-1:0] d_o = data_q[p*PORT_W +: PORT_W];
         wire logic [PORT_W-1:0] r_o = dir_q[p*PORT_W +: PORT_W];
         wire logic [PORT_W-1:0] m_o = mask_q[p*PORT_W +: PORT_W];
         wire logic [PORT_W-1:0] e_o = edge_q[p*PORT_W +: PORT_W];
         wire logic [PORT_W-1:0] b_o = both_q[p*PORT_W +: PORT_W];
         wire logic [PORT_W-1:0] s_o = stat_q[p*PORT_W +: PORT_W];
         wire logic [DW-1:0] d_w = w1m({{PADW{1'b0}}, d_o}, wdata, op);
         wire logic [DW-1:0] r_w = w1m({{PADW{1'b0}}, r_o}, wdata, op);
         wire logic [DW-1:0] m_w = w1m({{PADW{1'b0}}, m_o}, wdata, op);

         assign data_d[p*PORT_W +: PORT_W] = (whit && grp == G_DATA) ?
                d_w[PORT_W-1:0] : d_o; // RL2
         assign dir_d[p*PORT_W +: PORT_W]  = (whit && grp == G_DIR && plain) ?
                r_w[PORT_W-1:0] : r_o; // RL1 RL2
         assign mask_d[p*PORT_W +: PORT_W] = (whit && grp == G_MASK && plain) ?
                m_w[PORT_W-1:0] : m_o; // RL3 RL2
         assign edge_d[p*PORT_W +: PORT_W] = (whit && grp == G_MISC && addr[3:2] == M_EDGE) ?
                wdata[PORT_W-1:0] : e_o; // RL5
         assign both_d[p*PORT_W +: PORT_W] = (whit && grp == G_MISC && addr[3:2] == M_BOTH) ?
                wdata[PORT_W-1:0] : b_o; // RL5
         // A read clears the sticky bits, but an event in the same cycle survives
         assign stat_d[p*PORT_W +: PORT_W] = (s_o & ~{PORT_W{rclr}}) |
                ev[p*PORT_W +: PORT_W];

         assign port_rv[p] = (grp == G_DATA)           ? {{PADW{1'b0}}, d_o} :
                             (grp == G_DIR && plain)   ? {{PADW{1'b0}}, r_o} :
                             (grp == G_MASK && plain)  ? {{PADW{1'b0}}, m_o} :
                             (grp != G_MISC)           ? {DW{1'b0}} :
                             (addr[3:2] == M_EDGE)     ? {{PADW{1'b0}}, e_o} :
                             (addr[3:2] == M_BOTH)     ? {{PADW{1'b0}}, b_o} :
                             (addr[3:2] == M_STAT)     ? {{PADW{1'b0}}, s_o} :
                             {{PADW{1'b0}}, pin_in[p*PORT_W +: PORT_W]};
      end
   endgenerate

   // Level: source high; edge: rising, plus falling when both edges chosen
   assign ev = (edge_q & ((src & ~prev_q) | (both_q & ~src & prev_q))) |
               (~edge_q & src); // RL5

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         pint_if #(.NHALF(NHALF)) u_bus ();
         // Raw pins only, so channel setup never disturbs port behaviour
         assign u_bus.halves = pin_in; // RL7
         assign u_bus.wr     = wr && in_ch && (ch_ix == 3'(c)); // RL11
         assign u_bus.grp    = grp;
         assign u_bus.op     = addr[3:2];
         assign u_bus.wdata  = wdata;
         assign ch_rv[c]     = u_bus.rval;
         assign pin_irq_channels[c] = u_bus.irq; // RL8
         pint_channel #(.NHALF(NHALF)) u_ch (
            .clk   (clk),
            .rst_n (rst_n),
            .bus   (u_bus)
         );
      end
   endgenerate

   // Unmapped addresses read as zero
   assign rd_val = in_port ? port_rv[int'(port_ix) % NPORTS] :
                   in_ch   ? ch_rv[ch_ix] : {DW{1'b0}};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= '0;
         dir_q  <= '0;
         mask_q <= '0;
         edge_q <= '0;
         both_q <= '0;
         stat_q <= '0;
         prev_q <= '0;
      end else begin
         data_q <= data_d;
         dir_q  <= dir_d;
         mask_q <= mask_d;
         edge_q <= edge_d;
         both_q <= both_d;
         stat_q <= stat_d;
         prev_q <= src;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q    <= RST_WORD;
         gpio_irq_q <= 1'b0;
      end else begin
         rdata_q    <= rd ? rd_val : RST_WORD;
         gpio_irq_q <= |(stat_q & mask_q); // RL3
      end
   end

   assign rdata    = rdata_q;
   assign gpio_irq = gpio_irq_q;
   assign pin_out  = data_q;
   assign pin_oe   = dir_q; // RL1

   wire logic p0_w = wr && (addr[11:6] == 6'h00);

   sequence s_dir_set;
      p0_w && grp == G_DIR && addr[3:2] == 2'h1;
   endsequence
   sequence s_data_clr;
      p0_w && grp == G_DATA && addr[3:2] == 2'h2;
   endsequence
   sequence s_rise0;
      edge_q[0] && !src[0] ##1 edge_q[0] && src[0];
   endsequence
   sequence s_fall0_only;
      edge_q[0] && !both_q[0] && src[0] && prev_q[0] && !stat_q[0] ##1
      edge_q[0] && !both_q[0] && !src[0];
   endsequence

   a_dir_set_oe: assert property (@(posedge clk) disable iff (!rst_n) // RL1
      s_dir_set |=> (pin_oe[15:0] & $past(wdata[15:0])) == $past(wdata[15:0]))
      else $error("direction set did not enable outputs");
   a_data_clr_keep: assert property (@(posedge clk) disable iff (!rst_n) // RL2
      s_data_clr |=> pin_out[15:0] == ($past(pin_out[15:0]) & ~$past(wdata[15:0])))
      else $error("data clear disturbed other pins");
   a_mask_gate: assert property (@(posedge clk) disable iff (!rst_n) // RL3
      (stat_q & mask_q) == '0 |=> !gpio_irq)
      else $error("gpio irq without unmasked status");
   a_sw_trigger: assert property (@(posedge clk) disable iff (!rst_n) // RL4
      dir_q[0] && data_q[0] && !edge_q[0] |=> stat_q[0])
      else $error("output pin level did not set status");
   a_edge_rise: assert property (@(posedge clk) disable iff (!rst_n) // RL5
      s_rise0 |=> stat_q[0])
      else $error("rising edge not latched");
   a_fall_ignored: assert property (@(posedge clk) disable iff (!rst_n) // RL5
      s_fall0_only |=> !stat_q[0])
      else $error("falling edge latched in rising-only mode");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      !rd |=> rdata == '0)
      else $error("read data without read strobe");
endmodule
`default_nettype wire

// [inc/gpio_pkg.sv]
package gpio_pkg;
   localparam int AW     = 12;
   localparam int DW     = 32;
   localparam int PORT_W = 16;
   localparam int HALF_W = 8;
   localparam int NCH    = 8;
   localparam int LANES  = 4;

   // Address map: port regions at the bottom, channel regions above
   localparam logic [1:0] PORT_HI = 2'h0;
   localparam logic [2:0] CH_HI   = 3'h2;

   // Offset bits [5:4] pick a register group, bits [3:2] the access kind
   localparam logic [1:0] G_DATA  = 2'h0;
   localparam logic [1:0] G_DIR   = 2'h1;
   localparam logic [1:0] G_MASK  = 2'h2;
   localparam logic [1:0] G_MISC  = 2'h3;
   localparam logic [1:0] M_EDGE  = 2'h0;
   localparam logic [1:0] M_BOTH  = 2'h1;
   localparam logic [1:0] M_STAT  = 2'h2;
   localparam logic [1:0] M_PIN   = 2'h3;

   localparam logic [1:0] C_MASK  = 2'h0;
   localparam logic [1:0] C_EDGE  = 2'h1;
   localparam logic [1:0] C_INV   = 2'h2;
   localparam logic [1:0] C_PIN   = 2'h3;
   localparam logic [1:0] OP_XTRA = 2'h3;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {OP_WR, OP_SET, OP_CLR, OP_TGL} wop_t;

   function automatic logic [31:0] w1m(input logic [31:0] old,
                                       input logic [31:0] wd,
                                       input wop_t        op);
      logic [31:0] r;
      r = old;
      unique case (op)
         OP_WR:  r = wd;
         OP_SET: r = old | wd;
         OP_CLR: r = old & ~wd;
         OP_TGL: r = old ^ wd;
      endcase
      return r;
   endfunction
endpackage

// [inc/pint_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pint_if #(
   parameter int NHALF = 4
) ();
   logic [NHALF*8-1:0] halves;
   logic               wr;
   logic [1:0]         grp;
   logic [1:0]         op;
   logic [31:0]        wdata;
   logic [31:0]        rval;
   logic               irq;

   modport hub  (output halves, wr, grp, op, wdata, input  rval, irq);
   modport chan (input  halves, wr, grp, op, wdata, output rval, irq);
endinterface
`default_nettype wire

// [rtl/pint_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module pint_channel #(
   parameter int NHALF = 4
) (
   input  wire logic clk,
   input  wire logic rst_n,
   pint_if.chan      bus
);
   import gpio_pkg::*;
   localparam int IW = (NHALF > 1) ? $clog2(NHALF) : 1;

   logic [31:0] mask_q;
   logic [31:0] edge_q;
   logic [31:0] inv_q;
   logic [31:0] assign_q;
   logic [31:0] latch_q;
   logic [31:0] prev_q;
   logic        irq_q;
   logic [31:0] mask_d;
   logic [31:0] edge_d;
   logic [31:0] inv_d;
   logic [31:0] assign_d;
   logic [31:0] latch_d;
   logic [31:0] pins;
   logic [31:0] act;
   logic [31:0] rise;
   logic [31:0] clr;
   logic [31:0] req;
   wop_t        op;
   wire  logic  plain_op = bus.op != OP_XTRA;
   wire  logic [3:0] ro  = {bus.grp, bus.op};

   assign op = wop_t'(bus.op);

   // Each byte lane of the assignment word picks one half port
   genvar b;
   generate
      for (b = 0; b < LANES; b++) begin : g_lane
         wire logic [IW-1:0] idx = assign_q[b*8 +: IW];
         assign pins[b*HALF_W +: HALF_W] = (int'(idx) < NHALF) ?
                bus.halves[int'(idx)*HALF_W +: HALF_W] : 8'h00; // RL10 RL9
      end
   endgenerate

   assign act  = pins ^ inv_q; // RL6
   assign rise = act & ~prev_q;
   assign clr  = (bus.wr && bus.grp == C_EDGE && bus.op == OP_XTRA) ? bus.wdata : 32'h0;

   assign mask_d   = (bus.wr && bus.grp == C_MASK && plain_op) ?
                     w1m(mask_q, bus.wdata, op) : mask_q; // RL13
   assign edge_d   = (bus.wr && bus.grp == C_EDGE && plain_op) ?
                     w1m(edge_q, bus.wdata, op) : edge_q; // RL13
   assign inv_d    = (bus.wr && bus.grp == C_INV && plain_op) ?
                     w1m(inv_q, bus.wdata, op) : inv_q; // RL13
   assign assign_d = (bus.wr && bus.grp == C_INV && bus.op == OP_XTRA) ?
                     bus.wdata : assign_q; // RL10
   // Edge latches hold until a write of one clears them; a new edge wins
   assign latch_d  = (edge_q & ((latch_q & ~clr) | rise)) | (~edge_q & act); // RL14 RL6
   assign req      = latch_q & mask_q;

   // Latch and pin state stay readable whatever the mask says
   assign bus.rval = (ro == {C_MASK, OP_XTRA}) ? req :
                     (bus.grp == C_MASK)       ? mask_q :
                     (ro == {C_EDGE, OP_XTRA}) ? latch_q : // RL12
                     (bus.grp == C_EDGE)       ? edge_q :
                     (ro == {C_INV, OP_XTRA})  ? assign_q :
                     (bus.grp == C_INV)        ? inv_q :
                     (ro == {C_PIN, 2'h0})     ? pins : 32'h0; // RL11 RL12
   assign bus.irq  = irq_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q   <= RST_WORD;
         edge_q   <= RST_WORD;
         inv_q    <= RST_WORD;
         assign_q <= RST_WORD;
         latch_q  <= RST_WORD;
         prev_q   <= RST_WORD;
         irq_q    <= 1'b0;
      end else begin
         mask_q   <= mask_d;
         edge_q   <= edge_d;
         inv_q    <= inv_d;
         assign_q <= assign_d;
         latch_q  <= latch_d;
         prev_q   <= act;
         irq_q    <= |req; // RL8 RL3
      end
   end

   a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL14
      edge_q[0] && latch_q[0] && !clr[0] |=> latch_q[0])
      else $error("edge latch lost without clear");
   a_latch_clear: assert property (@(posedge clk) disable iff (!rst_n) // RL14
      edge_q[0] && clr[0] && !rise[0] |=> !latch_q[0])
      else $error("edge latch not cleared");
   a_level_polarity: assert property (@(posedge clk) disable iff (!rst_n) // RL6
      !edge_q[0] && (pins[0] != inv_q[0]) |=> latch_q[0])
      else $error("level request missing");
   a_chan_irq: assert property (@(posedge clk) disable iff (!rst_n) // RL8
      (latch_q & mask_q) == 32'h0 |=> !bus.irq)
      else $error("channel irq without unmasked request");
endmodule
`default_nettype wire

// [verification/gpio_pad_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Pads: a pin with its output enabled reads back its own drive, so the
// external level is ignored there, as on a real pad ring
module gpio_pad_model #(
   parameter int W = 32
) (
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe,
   output logic      [W-1:0] pin_in
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// [verification/gpio_with_pin_interrupts_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module gpio_with_pin_interrupts_tb;
   import gpio_pkg::*;
   logic           clk = 1'b0;
   logic           rst_n = 1'b0;
   logic [AW-1:0]  addr = '0;
   logic [DW-1:0]  wdata = '0;
   logic           wr = 1'b0;
   logic           rd = 1'b0;
   logic [DW-1:0]  rdata;
   logic [31:0]    ext = '0;
   logic [31:0]    pin_in;
   logic [31:0]    pin_out;
   logic [31:0]    pin_oe;
   logic           gpio_irq;
   logic [NCH-1:0] pin_irq_channels;
   int             err_total = 0;
   int             cmp_count = 0;

   always #12.5 clk = ~clk;

   gpio_pins gpio_pins_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .gpio_irq(gpio_irq), .pin_irq_channels(pin_irq_channels));
   gpio_pad_model gpio_pad_model_i (.ext(ext), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in));

   task automatic test_done;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic w(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data is only valid in the one cycle after the strobe
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Sources reach status or latch, then the registered irq: 2 edges
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic setp(input logic [31:0] v);
      @(posedge clk);
      ext <= v;
   endtask

   task automatic wait_irq(input logic want);
      int n;
      n = 0;
      // Step off the edge so the registered irq has settled before it is looked at
      #1;
      while (gpio_irq !== want && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp_count++;
      if (gpio_irq !== want) begin
         $display("MISMATCH t=%0t irq wait", $time);
         err_total++;
         test_done();
      end
   endtask

   task automatic t_reset_map;
      rchk(12'h000, 32'h0);
      rchk(12'h010, 32'h0);
      rchk(12'h42C, 32'h0);
      chk(pin_oe, 32'h0);
      w(12'h100, 32'hFFFF);
      rchk(12'h100, 32'h0);
      rchk(12'h01C, 32'h0);
   endtask

   task automatic t_port;
      w(12'h010, 32'h00F0);
      w(12'h014, 32'h0003);
      w(12'h018, 32'h0010);
      w(12'h000, 32'h00FF);
      w(12'h004, 32'h0100);
      w(12'h008, 32'h000F);
      w(12'h00C, 32'h0011);
      settle();
      chk(pin_oe, 32'h00E3);
      chk(pin_out, 32'h01E1);
      rchk(12'h010, 32'h00E3);
      w(12'h010, 32'h0);
      w(12'h000, 32'h0);
      settle();
      rchk(12'h03C, 32'h0);
      w(12'h038, 32'h0);
      rchk(12'h03C, 32'h0);
   endtask

   task automatic t_gpio_irq;
      // Output pins 0, 1, 5, 6 and 7 were driven high above, so their sticky bits stand
      rchk(12'h038, 32'h0000_00E3);
      w(12'h030, 32'h1);
      w(12'h024, 32'h1);
      setp(32'h1);
      wait_irq(1'b1);
      rchk(12'h038, 32'h1);
      wait_irq(1'b0);
      setp(32'h0);
      settle();
      rchk(12'h038, 32'h0);
      w(12'h034, 32'h1);
      setp(32'h1);
      settle();
      rchk(12'h038, 32'h1);
      setp(32'h0);
      wait_irq(1'b1);
      w(12'h028, 32'h1);
      rchk(12'h038, 32'h1);
      setp(32'h1);
      settle();
      chk({31'h0, gpio_irq}, 32'h0);
      rchk(12'h038, 32'h1);
      setp(32'h0);
      settle();
      rchk(12'h038, 32'h1);
   endtask

   task automatic t_out_irq;
      w(12'h014, 32'h2);
      w(12'h024, 32'h2);
      setp(32'h2);
      settle();
      chk({31'h0, gpio_irq}, 32'h0);
      w(12'h004, 32'h2);
      wait_irq(1'b1);
      w(12'h008, 32'h2);
      rchk(12'h038, 32'h2);
      wait_irq(1'b0);
      w(12'h028, 32'h2);
   endtask

   task automatic t_chan;
      for (int c = 0; c < NCH; c++) begin
         w(12'h404 + 12'(c * 64), 32'h1);
      end
      setp(32'h1);
      settle();
      chk({24'h0, pin_irq_channels}, 32'hFF);
      setp(32'h0);
      settle();
      chk({24'h0, pin_irq_channels}, 32'h0);
      w(12'h414, 32'h1);
      setp(32'h1);
      settle();
      setp(32'h0);
      settle();
      chk({24'h0, pin_irq_channels}, 32'h01);
      rchk(12'h41C, 32'h1);
      rchk(12'h40C, 32'h1);
      w(12'h41C, 32'h1);
      settle();
      chk({24'h0, pin_irq_channels}, 32'h0);
      w(12'h418, 32'h1);
      rchk(12'h410, 32'h0);
      w(12'h408, 32'h1);
      rchk(12'h400, 32'h0);
      chk(pin_oe, 32'h0002);
      chk(pin_out, 32'h0);
   endtask

   task automatic t_chan_map;
      setp(32'hA5C3_5A00);
      w(12'h46C, 32'h0302_0100);
      settle();
      rchk(12'h470, 32'hA5C3_5A00);
      w(12'h46C, 32'h0302_0103);
      w(12'h464, 32'h2);
      settle();
      rchk(12'h470, 32'hA5C3_5AA5);
      rchk(12'h45C, 32'hA5C3_5AA7);
      rchk(12'h44C, 32'h1);
      chk({31'h0, pin_irq_channels[1]}, 32'h1);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_map();
      t_port();
      t_gpio_irq();
      t_out_irq();
      t_chan();
      t_chan_map();
      test_done();
   end

   // Guard against a hang anywhere in the sequence
   initial begin
      #2000000;
      $display("MISMATCH t=%0t timeout", $time);
      err_total++;
      test_done();
   end
endmodule
`default_nettype wire
